// File: dv/mfq_host_model.sv
// host processor model: four-phase port accesses
// assumes the unit acks each request with a level
`timescale 1ns/1ps
`default_nettype none
module mfq_host_model (
   input wire logic core_clk_i, // clock
   input wire logic host_ack_i, // unit ack
   output var mfq_pkg::mfq_host_req_t host_req_o // request
);
   import mfq_pkg::*;
   initial host_req_o = '0;
   // data inverted once released
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      // no local limit: a hang is left to the bench watchdog
      @(posedge core_clk_i);
      host_req_o <= '{1'b1, we, a, d};
      while (!host_ack_i) begin
         @(posedge core_clk_i);
      end
      host_req_o <= '{1'b0, we, a, ~d};
      while (host_ack_i) begin
         @(posedge core_clk_i);
      end
   endtask
endmodule // mfq_host_model
`default_nettype wire

// File: dv/mfq_monitor.sv
// port checker of the frame queue unit
// assumes a bind onto mfq_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module mfq_monitor (
   input wire logic core_clk_i, // clock
   input wire logic reset_i, // reset
   input wire mfq_pkg::mfq_host_req_t host_req_i, // host request
   input wire logic host_ack_o, // host ack
   input wire mfq_pkg::mfq_core_req_t core_req_i, // core access
   input wire logic core_ack_o, // core ack
   input wire mfq_pkg::mfq_mem_req_t mem_req_o, // sdram request
   input wire logic mem_ack_i, // sdram ack
   input wire logic core_irq_o, // core irq
   input wire logic pci_int_n_o, // pci level
   input wire logic pci_int_oe_o // pci enable
);
   import mfq_pkg::*;
   logic im_reg, im_next, om_reg, om_next;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   // shadow of both mask bits
   always_comb begin
      im_next = im_reg;
      om_next = om_reg;
      if (core_req_i.sel && core_req_i.we && core_req_i.addr == REG_CORE_IRQ_MASK) begin
         im_next = core_req_i.wdata[0];
      end
      if (core_req_i.sel && core_req_i.we && core_req_i.addr == REG_OUTB_IRQ_MASK) begin
         om_next = core_req_i.wdata[0];
      end
   end
   always_ff @(posedge core_clk_i) begin
      im_reg <= reset_i ? 1'b0 : im_next;
      om_reg <= reset_i ? 1'b0 : om_next;
   end
   sequence mem_done_s;
      mem_req_o.valid && mem_ack_i;
   endsequence
   mem_then_ack_a: assert property (mem_done_s |=> host_ack_o)
      else $error("host ack missing");
   mem_hold_a: assert property (mem_req_o.valid && !mem_ack_i |=> $stable(mem_req_o))
      else $error("sdram request moved");
   mem_align_a: assert property (mem_req_o.valid |-> mem_req_o.addr[1:0] == 2'b00)
      else $error("sdram address unaligned");
   core_ack_a: assert property (core_req_i.sel |=> core_ack_o)
      else $error("core ack missing");
   irq_cause_a: assert property ($rose(core_irq_o) |-> $past(host_ack_o) || $past(core_ack_o))
      else $error("core irq without cause");
   irq_mask_a: assert property (!im_reg |=> !core_irq_o)
      else $error("core irq while masked");
   irq_hold_a: assert property (core_irq_o && !core_ack_o |=> core_irq_o)
      else $error("core irq dropped");
   pci_mask_a: assert property (om_reg |=> !pci_int_oe_o)
      else $error("pci irq while masked");
   pci_low_a: assert property (pci_int_n_o == 1'b0)
      else $error("pci irq level high");
   ack_stand_a: assert property (host_ack_o && host_req_i.req |=> host_ack_o)
      else $error("host ack dropped early");
   ack_end_a: assert property (!host_req_i.req [*5] |-> !host_ack_o)
      else $error("host ack stuck");
endmodule // mfq_monitor
`default_nettype wire

// File: dv/test_message_frame_queue_unit.sv
// self-checking bench of the frame queue unit, sdram model inside
// assumes the package, unit, monitor and host model compile first
`timescale 1ns/1ps
`default_nettype none
module test_message_frame_queue_unit;
   import mfq_pkg::*;
   logic core_clk_i = 1'b0;
   logic pci_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic mem_ack_i = 1'b0;
   logic hack_q = 1'b0;
   logic [31:0] mem_rdata_i = '0;
   mfq_core_req_t core_req_i = '0;
   wire mfq_host_req_t host_req_i;
   logic host_ack_o, core_ack_o, core_irq_o, pci_int_n_o, pci_int_oe_o;
   logic [31:0] host_rdata_o, core_rdata_o, a;
   mfq_mem_req_t mem_req_o;
   logic [31:0] mem [logic [31:0]];
   logic [31:0] f [4];
   logic [32:0] cq [$], hq [$], n;
   int bad_count = 0;
   int compares = 0;
   int i;
   mfq_top u_mfq_top (.core_clk_i, .reset_i, .pci_clk_i, .host_req_i, .host_ack_o, .host_rdata_o, .core_req_i,
      .core_ack_o, .core_rdata_o, .mem_req_o, .mem_ack_i, .mem_rdata_i, .core_irq_o, .pci_int_n_o, .pci_int_oe_o);
   mfq_host_model u_mfq_host_model (.core_clk_i, .host_ack_i(host_ack_o), .host_req_o(host_req_i));
   always #2 core_clk_i = ~core_clk_i;
   always #32 pci_clk_i = ~pci_clk_i;
   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] e);
      compares++;
      if (seen !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", s, e, seen);
      end
   endtask
   task automatic end_sim;
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic creg(input logic we, input logic [7:0] r, input logic [31:0] d, input logic c, input logic [31:0] e);
      cq.push_back({c, e});
      @(posedge core_clk_i);
      core_req_i <= '{1'b1, we, r, d};
      @(posedge core_clk_i);
      core_req_i.sel <= 1'b0;
   endtask
   task automatic cw(input logic [7:0] r, input logic [31:0] d);
      creg(1'b1, r, d, 1'b0, ZERO_WORD);
   endtask
   task automatic cr(input logic [7:0] r, input logic [31:0] e);
      creg(1'b0, r, ZERO_WORD, 1'b1, e);
   endtask
   task automatic hx(input logic we, input logic [7:0] r, input logic [31:0] d, input logic c, input logic [31:0] e);
      hq.push_back({c, e});
      u_mfq_host_model.xfer(we, r, d);
   endtask
   // sdram: random latency, released data toggles
   always @(posedge core_clk_i) begin
      mem_ack_i <= 1'b0;
      mem_rdata_i <= ~mem_rdata_i;
      if (mem_req_o.valid && !mem_ack_i && $urandom_range(2) == 0) begin
         mem_ack_i <= 1'b1;
         mem_rdata_i <= mem[mem_req_o.addr];
         if (mem_req_o.we) mem[mem_req_o.addr] = mem_req_o.wdata;
      end
   end
   always @(posedge core_clk_i) begin
      hack_q <= host_ack_o;
      if (core_ack_o && cq.size() > 0) begin
         n = cq.pop_front();
         if (n[32]) check("core read", core_rdata_o, n[31:0]);
      end
      if (host_ack_o && !hack_q && hq.size() > 0) begin
         n = hq.pop_front();
         if (n[32]) check("host read", host_rdata_o, n[31:0]);
      end
   end
   // whole run needs a few hundred cycles
   initial begin
      #200000;
      bad_count++;
      end_sim();
   end
   initial begin
      void'($urandom(35763));
      for (i = 0; i < 4; i++) begin
         f[i] = $urandom() >> 1;
         mem[32'h1000 + 4 * i] = f[i];
      end
      repeat (16) @(posedge core_clk_i);
      reset_i <= 1'b0;
      cw(REG_INB_FREE_HEAD, 32'h1000);
      cw(REG_INB_POST_TAIL, 32'h2000);
      cw(REG_OUTB_FREE_TAIL, 32'h3000);
      cw(REG_OUTB_POST_HEAD, 32'h4000);
      cw(REG_CORE_IRQ_MASK, ONE_WORD);
      for (i = 0; i < 3; i++) cw(REG_INB_FREE_COUNT, ZERO_WORD);
      cr(REG_INB_FREE_COUNT, 32'h3);
      cr(REG_OUTB_FREE_TAIL, 32'h3000);
      for (i = 0; i < 3; i++) hx(1'b0, HOST_IN_PORT, ZERO_WORD, 1'b1, f[i]);
      hx(1'b0, HOST_IN_PORT, ZERO_WORD, 1'b1, INVALID_FRAME);
      cr(REG_INB_FREE_HEAD, 32'h100C);
      cr(REG_INB_FREE_COUNT, ZERO_WORD);
      for (i = 0; i < 2; i++) hx(1'b1, HOST_IN_PORT, f[i], 1'b0, ZERO_WORD);
      for (i = 0; i < 2; i++) check("post entry", mem[32'h2000 + 4 * i], f[i]);
      cr(REG_INB_POST_COUNT, 32'h2);
      check("core irq", {31'h0, core_irq_o}, ONE_WORD);
      cw(REG_INB_POST_COUNT, ZERO_WORD);
      cr(REG_INB_POST_COUNT, ONE_WORD);
      check("core irq held", {31'h0, core_irq_o}, ONE_WORD);
      cw(REG_INB_POST_COUNT, ZERO_WORD);
      repeat (3) @(posedge core_clk_i);
      check("core irq off", {31'h0, core_irq_o}, ZERO_WORD);
      mem[32'h100C] = f[0];
      cw(REG_INB_FREE_COUNT, ZERO_WORD);
      hx(1'b0, HOST_IN_PORT, ZERO_WORD, 1'b1, f[0]);
      cw(REG_CORE_IRQ_MASK, ZERO_WORD);
      hx(1'b1, HOST_IN_PORT, f[2], 1'b0, ZERO_WORD);
      repeat (4) @(posedge core_clk_i);
      check("core irq masked", {31'h0, core_irq_o}, ZERO_WORD);
      cw(REG_INB_POST_COUNT, ZERO_WORD);
      mem[32'h4000] = f[3];
      cw(REG_OUTB_POST_COUNT, ZERO_WORD);
      repeat (3) @(posedge core_clk_i);
      check("pci irq", {31'h0, pci_int_oe_o}, ONE_WORD);
      cw(REG_OUTB_IRQ_MASK, ONE_WORD);
      repeat (3) @(posedge core_clk_i);
      check("pci irq masked", {31'h0, pci_int_oe_o}, ZERO_WORD);
      cw(REG_OUTB_IRQ_MASK, ZERO_WORD);
      hx(1'b0, HOST_OUT_PORT, ZERO_WORD, 1'b1, f[3]);
      cr(REG_OUTB_POST_COUNT, ZERO_WORD);
      check("pci irq off", {31'h0, pci_int_oe_o}, ZERO_WORD);
      hx(1'b0, HOST_OUT_PORT, ZERO_WORD, 1'b1, INVALID_FRAME);
      hx(1'b1, HOST_OUT_PORT, f[0], 1'b0, ZERO_WORD);
      check("free entry", mem[32'h3000], f[0]);
      for (i = 0; i < 8; i++) begin
         a = 32'h100000 + (32'h1000 << i) - 32'h4;
         cw(REG_SYSTEM_CONTROL, {19'h0, i[2:0], 10'h0});
         cw(REG_INB_POST_TAIL, a);
         hx(1'b1, HOST_IN_PORT, f[i], 1'b0, ZERO_WORD);
         check("wrap entry", mem[a], f[i]);
         cr(REG_INB_POST_TAIL, 32'h100000);
      end
      hx(1'b0, 8'h48, ZERO_WORD, 1'b1, ZERO_WORD);
      cr(8'hFC, ZERO_WORD);
      repeat (20) @(posedge core_clk_i);
      check("pending notes", 32'(cq.size() + hq.size()), ZERO_WORD);
      end_sim();
   end
endmodule // test_message_frame_queue_unit
bind mfq_top mfq_monitor u_mfq_monitor (.core_clk_i, .reset_i, .host_req_i, .host_ack_o, .core_req_i, .core_ack_o,
   .mem_req_o, .mem_ack_i, .core_irq_o, .pci_int_n_o, .pci_int_oe_o);
`default_nettype wire

// File: verilog/mfq_pkg.sv
// constants and carrier types of the message frame queue unit
// assumes one 250 MHz core clock and a sampled host link clock
//
// How it works
// RULE1: host ports sit at 40h and 44h
// RULE2: four frame queues live in SDRAM
// RULE3: frame values opaque; all-ones means invalid
// RULE4: one queue size from control bits 12:10
// RULE5: hardware keeps four of eight pointers
// RULE6: core sets up inbound queues and counts
// RULE7: host inbound read pops inbound free head
// RULE8: host inbound write posts, bumps post count
// RULE9: core interrupt after write lands, masked
// RULE10: core interrupt held while posts remain
// RULE11: core decrements inbound post count per pop
// RULE12: core returns frames, bumps inbound free count
// RULE13: core sets outbound pointers, host fills free
// RULE14: core posts replies, bumps outbound post count
// RULE15: pci interrupt while outbound posts, unless masked
// RULE16: host outbound read pops post head, decrements
// RULE17: host outbound write appends to outbound free
// RULE18: inbound carries requests, outbound carries replies
// RULE19: all frames start on free queues
// RULE20: pointers step one word, wrap at size
// RULE21: empty read returns all-ones, changes nothing
package mfq_pkg;
   localparam logic [7:0] HOST_IN_PORT = 8'h40;
   localparam logic [7:0] HOST_OUT_PORT = 8'h44;
   localparam logic [7:0] REG_SYSTEM_CONTROL = 8'h00;
   localparam logic [7:0] REG_INB_FREE_HEAD = 8'h04;
   localparam logic [7:0] REG_INB_POST_TAIL = 8'h08;
   localparam logic [7:0] REG_OUTB_FREE_TAIL = 8'h0C;
   localparam logic [7:0] REG_OUTB_POST_HEAD = 8'h10;
   localparam logic [7:0] REG_INB_FREE_COUNT = 8'h14;
   localparam logic [7:0] REG_INB_POST_COUNT = 8'h18;
   localparam logic [7:0] REG_OUTB_POST_COUNT = 8'h1C;
   localparam logic [7:0] REG_OUTB_IRQ_MASK = 8'h20;
   localparam logic [7:0] REG_CORE_IRQ_MASK = 8'h24;
   localparam int QSIZE_LSB = 10;
   localparam int QSIZE_MSB = 12;
   localparam logic [31:0] QBYTES_MIN = 32'h0000_1000;
   localparam logic [31:0] ENTRY_BYTES = 32'h0000_0004;
   localparam logic [31:0] INVALID_FRAME = 32'hFFFF_FFFF;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [31:0] ONE_WORD = 32'h0000_0001;

   typedef enum logic [1:0] {
      MFQ_IDLE = 2'b00,
      MFQ_MEM = 2'b01,
      MFQ_DONE = 2'b10
   } mfq_state_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [7:0] addr;
      logic [31:0] wdata;
   } mfq_host_req_t;

   typedef struct packed {
      logic sel;
      logic we;
      logic [7:0] addr;
      logic [31:0] wdata;
   } mfq_core_req_t;

   typedef struct packed {
      logic valid;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mfq_mem_req_t;
endpackage

// File: verilog/mfq_sync.sv
// two-flop synchroniser for levels from another clock domain
// assumes multi-bit words are held stable while sampled
`timescale 1ns/1ps
`default_nettype none
module mfq_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i, // sampling clock
   input wire logic reset_i, // synchronous, active high
   input wire logic [WIDTH-1:0] async_i, // foreign level
   output logic [WIDTH-1:0] sync_o // synchronised level
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   always_comb begin
      meta_next = async_i;
      sync_next = meta_reg;
      if (reset_i) begin
         meta_next = '0;
         sync_next = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
   end

   assign sync_o = sync_reg;
endmodule // mfq_sync
`default_nettype wire

// File: verilog/mfq_top.sv
// message frame queue unit: host ports, core registers, SDRAM side
// assumes host holds request and data stable until it sees ack
`timescale 1ns/1ps
`default_nettype none
module mfq_top (
   input wire logic core_clk_i, // 250 MHz core clock
   input wire logic reset_i, // synchronous, active high
   input wire logic pci_clk_i, // host link clock, sampled
   input wire mfq_pkg::mfq_host_req_t host_req_i, // host port request
   output logic host_ack_o, // host request done
   output logic [31:0] host_rdata_o, // host read data
   input wire mfq_pkg::mfq_core_req_t core_req_i, // core register access
   output logic core_ack_o, // core access pulse
   output logic [31:0] core_rdata_o, // core read data
   output mfq_pkg::mfq_mem_req_t mem_req_o, // SDRAM request
   input wire logic mem_ack_i, // SDRAM done pulse
   input wire logic [31:0] mem_rdata_i, // SDRAM read data
   output logic core_irq_o, // inbound post interrupt
   output logic pci_int_n_o, // pci interrupt drive level
   output logic pci_int_oe_o // pci interrupt enable
);
   import mfq_pkg::*;

   localparam int HW = $bits(mfq_host_req_t);

   logic [HW-1:0] host_sync;
   logic pclk_sync;
   mfq_host_req_t hreq;

   mfq_sync #(.WIDTH(HW)) u_host_sync (
      .clk_i(core_clk_i),
      .reset_i(reset_i),
      .async_i(host_req_i),
      .sync_o(host_sync)
   );

   mfq_sync #(.WIDTH(1)) u_pclk_sync (
      .clk_i(core_clk_i),
      .reset_i(reset_i),
      .async_i(pci_clk_i),
      .sync_o(pclk_sync)
   );

   assign hreq = host_sync;

   mfq_state_t state_reg, state_next;
   logic pclk_prev_reg, pclk_prev_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] ifh_reg, ifh_next; // inbound free head
   logic [31:0] ipt_reg, ipt_next; // inbound post tail
   logic [31:0] oft_reg, oft_next; // outbound free tail
   logic [31:0] oph_reg, oph_next; // outbound post head
   logic [31:0] ifc_reg, ifc_next; // inbound free count
   logic [31:0] ipc_reg, ipc_next; // inbound post count
   logic [31:0] opc_reg, opc_next; // outbound post count
   logic out_mask_reg, out_mask_next;
   logic core_mask_reg, core_mask_next;
   logic host_ack_reg, host_ack_next;
   logic [31:0] host_rdata_reg, host_rdata_next;
   logic core_ack_reg, core_ack_next;
   logic [31:0] core_rdata_reg, core_rdata_next;
   mfq_mem_req_t mem_reg, mem_next;
   logic core_irq_reg, core_irq_next;
   logic pci_oe_reg, pci_oe_next;
   logic pclk_rise;
   logic [31:0] qmask;

   // step one entry inside the size-aligned queue window
   function automatic logic [31:0] advance(input logic [31:0] ptr, input logic [31:0] m);
      logic [31:0] stepped;
      stepped = ptr + ENTRY_BYTES;
      return (ptr & ~m) | (stepped & m); // [RULE20]
   endfunction

   assign pclk_rise = pclk_sync & ~pclk_prev_reg;
   assign qmask = (QBYTES_MIN << ctrl_reg[QSIZE_MSB:QSIZE_LSB]) - ONE_WORD; // [RULE4]

   always_comb begin
      state_next = state_reg;
      pclk_prev_next = pclk_sync;
      ctrl_next = ctrl_reg;
      ifh_next = ifh_reg;
      ipt_next = ipt_reg;
      oft_next = oft_reg;
      oph_next = oph_reg;
      ifc_next = ifc_reg;
      ipc_next = ipc_reg;
      opc_next = opc_reg;
      out_mask_next = out_mask_reg;
      core_mask_next = core_mask_reg;
      host_ack_next = host_ack_reg;
      host_rdata_next = host_rdata_reg;
      core_ack_next = 1'b0;
      core_rdata_next = core_rdata_reg;
      mem_next = mem_reg;

      // host side sequencer; frame values pass through untouched [RULE3]
      unique case (state_reg)
         MFQ_IDLE: begin
            if (pclk_rise && hreq.req) begin
               if (hreq.addr == HOST_IN_PORT) begin // [RULE1]
                  if (hreq.we) begin
                     mem_next = '{valid: 1'b1, we: 1'b1, addr: ipt_reg, wdata: hreq.wdata}; // [RULE8] [RULE2] [RULE18]
                     state_next = MFQ_MEM;
                  end else if (ifc_reg != ZERO_WORD) begin
                     mem_next = '{valid: 1'b1, we: 1'b0, addr: ifh_reg, wdata: ZERO_WORD}; // [RULE7]
                     state_next = MFQ_MEM;
                  end else begin
                     host_rdata_next = INVALID_FRAME; // [RULE21]
                     host_ack_next = 1'b1;
                     state_next = MFQ_DONE;
                  end
               end else if (hreq.addr == HOST_OUT_PORT) begin // [RULE1]
                  if (hreq.we) begin
                     mem_next = '{valid: 1'b1, we: 1'b1, addr: oft_reg, wdata: hreq.wdata}; // [RULE17]
                     state_next = MFQ_MEM;
                  end else if (opc_reg != ZERO_WORD) begin
                     mem_next = '{valid: 1'b1, we: 1'b0, addr: oph_reg, wdata: ZERO_WORD}; // [RULE16] [RULE18]
                     state_next = MFQ_MEM;
                  end else begin
                     host_rdata_next = INVALID_FRAME; // [RULE21]
                     host_ack_next = 1'b1;
                     state_next = MFQ_DONE;
                  end
               end else begin
                  host_rdata_next = ZERO_WORD;
                  host_ack_next = 1'b1;
                  state_next = MFQ_DONE;
               end
            end
         end
         MFQ_MEM: begin
            if (mem_ack_i) begin
               mem_next.valid = 1'b0;
               host_ack_next = 1'b1;
               state_next = MFQ_DONE;
               if (!mem_reg.we) begin
                  host_rdata_next = mem_rdata_i;
               end
               // pointers and counts move only once SDRAM has finished
               if (hreq.addr == HOST_IN_PORT) begin
                  if (mem_reg.we) begin
                     ipt_next = advance(ipt_reg, qmask); // [RULE20]
                     ipc_next = ipc_reg + ONE_WORD; // [RULE8] [RULE9]
                  end else begin
                     ifh_next = advance(ifh_reg, qmask); // [RULE7]
                     ifc_next = ifc_reg - ONE_WORD; // [RULE7]
                  end
               end else begin
                  if (mem_reg.we) begin
                     oft_next = advance(oft_reg, qmask); // [RULE17]
                  end else begin
                     oph_next = advance(oph_reg, qmask); // [RULE16]
                     opc_next = opc_reg - ONE_WORD; // [RULE16]
                  end
               end
            end
         end
         MFQ_DONE: begin
            if (!hreq.req) begin
               host_ack_next = 1'b0;
               state_next = MFQ_IDLE;
            end
         end
         default: begin
            state_next = MFQ_IDLE;
         end
      endcase

      // core register port; count writes adjust by one, on top of host moves
      if (core_req_i.sel) begin
         core_ack_next = 1'b1;
         if (core_req_i.we) begin
            unique case (core_req_i.addr)
               REG_SYSTEM_CONTROL: ctrl_next = core_req_i.wdata;
               REG_INB_FREE_HEAD: ifh_next = core_req_i.wdata; // [RULE5] [RULE6]
               REG_INB_POST_TAIL: ipt_next = core_req_i.wdata; // [RULE5] [RULE6]
               REG_OUTB_FREE_TAIL: oft_next = core_req_i.wdata; // [RULE5] [RULE13]
               REG_OUTB_POST_HEAD: oph_next = core_req_i.wdata; // [RULE5] [RULE13]
               REG_INB_FREE_COUNT: ifc_next = ifc_next + ONE_WORD; // [RULE6] [RULE12]
               REG_INB_POST_COUNT: ipc_next = ipc_next - ONE_WORD; // [RULE11]
               REG_OUTB_POST_COUNT: opc_next = opc_next + ONE_WORD; // [RULE14]
               REG_OUTB_IRQ_MASK: out_mask_next = core_req_i.wdata[0];
               REG_CORE_IRQ_MASK: core_mask_next = core_req_i.wdata[0];
               default: core_rdata_next = core_rdata_reg;
            endcase
         end else begin
            unique case (core_req_i.addr)
               REG_SYSTEM_CONTROL: core_rdata_next = ctrl_reg;
               REG_INB_FREE_HEAD: core_rdata_next = ifh_reg;
               REG_INB_POST_TAIL: core_rdata_next = ipt_reg;
               REG_OUTB_FREE_TAIL: core_rdata_next = oft_reg;
               REG_OUTB_POST_HEAD: core_rdata_next = oph_reg;
               REG_INB_FREE_COUNT: core_rdata_next = ifc_reg;
               REG_INB_POST_COUNT: core_rdata_next = ipc_reg;
               REG_OUTB_POST_COUNT: core_rdata_next = opc_reg;
               REG_OUTB_IRQ_MASK: core_rdata_next = {31'h0000_0000, out_mask_reg};
               REG_CORE_IRQ_MASK: core_rdata_next = {31'h0000_0000, core_mask_reg};
               default: core_rdata_next = ZERO_WORD;
            endcase
         end
      end

      core_irq_next = (ipc_reg != ZERO_WORD) && core_mask_reg; // [RULE9] [RULE10]
      pci_oe_next = (opc_reg != ZERO_WORD) && !out_mask_reg; // [RULE15]

      if (reset_i) begin
         state_next = MFQ_IDLE;
         pclk_prev_next = 1'b0;
         ctrl_next = ZERO_WORD;
         ifh_next = ZERO_WORD;
         ipt_next = ZERO_WORD;
         oft_next = ZERO_WORD;
         oph_next = ZERO_WORD;
         ifc_next = ZERO_WORD;
         ipc_next = ZERO_WORD; // [RULE19]
         opc_next = ZERO_WORD; // [RULE19]
         out_mask_next = 1'b0;
         core_mask_next = 1'b0;
         host_ack_next = 1'b0;
         host_rdata_next = ZERO_WORD;
         core_ack_next = 1'b0;
         core_rdata_next = ZERO_WORD;
         mem_next = '0;
         core_irq_next = 1'b0;
         pci_oe_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      state_reg <= state_next;
      pclk_prev_reg <= pclk_prev_next;
      ctrl_reg <= ctrl_next;
      ifh_reg <= ifh_next;
      ipt_reg <= ipt_next;
      oft_reg <= oft_next;
      oph_reg <= oph_next;
      ifc_reg <= ifc_next;
      ipc_reg <= ipc_next;
      opc_reg <= opc_next;
      out_mask_reg <= out_mask_next;
      core_mask_reg <= core_mask_next;
      host_ack_reg <= host_ack_next;
      host_rdata_reg <= host_rdata_next;
      core_ack_reg <= core_ack_next;
      core_rdata_reg <= core_rdata_next;
      mem_reg <= mem_next;
      core_irq_reg <= core_irq_next;
      pci_oe_reg <= pci_oe_next;
   end

   assign host_ack_o = host_ack_reg;
   assign host_rdata_o = host_rdata_reg;
   assign core_ack_o = core_ack_reg;
   assign core_rdata_o = core_rdata_reg;
   assign mem_req_o = mem_reg;
   assign core_irq_o = core_irq_reg;
   assign pci_int_oe_o = pci_oe_reg;
   assign pci_int_n_o = 1'b0; // open drain: only ever pulls low
endmodule // mfq_top
`default_nettype wire
